// ===== shared/xdl_pkg.sv
// Purpose: Constants for the xor and direction-load execution block
// Assumes: 8-bit datapath, 7-bit file address
// Notes: Opcode selection comes from the core decoder as a one-hot strobe set
// Summary of operation
// [RULE1] The direction-load instruction accepts only operands five to seven and copies the accumulator unchanged.
// [RULE2] Operand 5 loads the port A direction register, 6 port B and 7 port C.
// [RULE3] The literal XOR combines the accumulator with an 8-bit immediate and writes the accumulator.
// [RULE4] The file XOR combines the accumulator with file f and writes the accumulator when d is 0, else f.
// [RULE5] Both XORs update only the zero flag from the 8-bit result; the direction load touches no flag.
package xdl_pkg;
  localparam int XDL_DATA_W = 8;
  localparam int XDL_ADDR_W = 7;
  localparam logic [2:0] XDL_DIR_SEL_A = 3'h5;
  localparam logic [2:0] XDL_DIR_SEL_B = 3'h6;
  localparam logic [2:0] XDL_DIR_SEL_C = 3'h7;
  localparam logic [7:0] XDL_ACC_RST = 8'h00;
  localparam logic [7:0] XDL_DIR_RST = 8'hFF;
  localparam logic XDL_ZERO_RST = 1'h0;
  localparam logic XDL_PULSE_RST = 1'h0;
  localparam logic [6:0] XDL_WADDR_RST = 7'h00;
  localparam logic [7:0] XDL_WDATA_RST = 8'h00;
  localparam logic XDL_DEST_ACC = 1'h0;
  localparam logic XDL_DEST_FILE = 1'h1;
endpackage

// ===== src/xdl_exec.sv
// Purpose: Executes direction-load, literal XOR and file XOR instructions
// Assumes: File operand read data is valid in the cycle the file XOR strobe is high
// Notes: One instruction strobe at a time; the file write is a one-cycle pulse
`timescale 1ns/10ps
module xdl_exec
  import xdl_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_load_port_direction,
  input wire logic [2:0] i_dir_sel,
  input wire logic i_xor_literal_into_acc,
  input wire logic [xdl_pkg::XDL_DATA_W-1:0] i_literal,
  input wire logic i_xor_acc_with_file,
  input wire logic [xdl_pkg::XDL_ADDR_W-1:0] i_file_addr,
  input wire logic i_dest_sel,
  input wire logic [xdl_pkg::XDL_DATA_W-1:0] i_file_rdata,
  input wire logic i_zero_in,
  output logic [xdl_pkg::XDL_DATA_W-1:0] o_acc,
  output logic o_zero,
  output logic [xdl_pkg::XDL_DATA_W-1:0] o_port_a_direction_reg,
  output logic [xdl_pkg::XDL_DATA_W-1:0] o_port_b_direction_reg,
  output logic [xdl_pkg::XDL_DATA_W-1:0] o_port_c_direction_reg,
  output logic o_file_we,
  output logic [xdl_pkg::XDL_ADDR_W-1:0] o_file_waddr,
  output logic [xdl_pkg::XDL_DATA_W-1:0] o_file_wdata,
  output logic o_illegal_operand
);
  import xdl_pkg::*;

  // Direction register count and the operand that selects each one
  localparam int XDL_NUM_DIR = 3;
  localparam logic [2:0] XDL_DIR_CODE [XDL_NUM_DIR] = '{
    XDL_DIR_SEL_A,
    XDL_DIR_SEL_B,
    XDL_DIR_SEL_C
  };

  // One-hot view of the instruction taken this cycle
  typedef enum logic [3:0] {
    XDL_OP_IDLE = 4'h1,
    XDL_OP_DIR = 4'h2,
    XDL_OP_LIT = 4'h4,
    XDL_OP_FILE = 4'h8
  } xdl_op_e;

  // Operand matches one direction register
  function automatic logic dir_hit(
    input logic [2:0] sel,
    input logic [2:0] code
  );
    dir_hit = (sel == code);
  endfunction

  // Operand names one of the three direction registers
  function automatic logic dir_legal(
    input logic [2:0] sel
  );
    dir_legal = dir_hit(sel, XDL_DIR_SEL_A)
      || dir_hit(sel, XDL_DIR_SEL_B)
      || dir_hit(sel, XDL_DIR_SEL_C);
  endfunction

  // Whole result is zero
  function automatic logic res_zero(
    input logic [XDL_DATA_W-1:0] val
  );
    res_zero = (val == '0);
  endfunction

  xdl_op_e op;
  logic [XDL_DATA_W-1:0] lit_res;
  logic [XDL_DATA_W-1:0] file_res;
  logic [XDL_DATA_W-1:0] acc_r;
  logic [XDL_DATA_W-1:0] acc_nxt;
  logic zero_r;
  logic zero_nxt;
  logic we_r;
  logic we_nxt;
  logic [XDL_ADDR_W-1:0] waddr_r;
  logic [XDL_ADDR_W-1:0] waddr_nxt;
  logic [XDL_DATA_W-1:0] wdata_r;
  logic [XDL_DATA_W-1:0] wdata_nxt;
  logic ill_r;
  logic ill_nxt;

  // Strobe priority: direction load, then literal XOR, then file XOR
  always_comb begin
    if (i_load_port_direction) begin
      op = XDL_OP_DIR;
    end else if (i_xor_literal_into_acc) begin
      op = XDL_OP_LIT;
    end else if (i_xor_acc_with_file) begin
      op = XDL_OP_FILE;
    end else begin
      op = XDL_OP_IDLE;
    end
  end

  always_comb begin
    lit_res = acc_r ^ i_literal; // [RULE3]
    file_res = acc_r ^ i_file_rdata; // [RULE4]
  end

  always_comb begin
    acc_nxt = acc_r;
    case (op)
      XDL_OP_LIT: begin
        acc_nxt = lit_res; // [RULE3]
      end
      XDL_OP_FILE: begin
        if (i_dest_sel == XDL_DEST_ACC) begin
          acc_nxt = file_res; // [RULE4]
        end
      end
      default: begin
        acc_nxt = acc_r;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      acc_r <= XDL_ACC_RST;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // Other instructions own the flag while this block is idle
  always_comb begin
    zero_nxt = zero_r;
    case (op)
      XDL_OP_IDLE: begin
        zero_nxt = i_zero_in;
      end
      XDL_OP_DIR: begin
        zero_nxt = zero_r; // [RULE5]
      end
      XDL_OP_LIT: begin
        zero_nxt = res_zero(lit_res); // [RULE5]
      end
      XDL_OP_FILE: begin
        zero_nxt = res_zero(file_res); // [RULE5]
      end
      default: begin
        zero_nxt = zero_r;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      zero_r <= XDL_ZERO_RST;
    end else begin
      zero_r <= zero_nxt;
    end
  end

  // A direction load copies the accumulator unchanged into one register
  for (genvar g = 0; g < XDL_NUM_DIR; g++) begin : g_dir
    logic [XDL_DATA_W-1:0] dir_r;
    logic [XDL_DATA_W-1:0] dir_nxt;

    always_comb begin
      dir_nxt = dir_r;
      if (op == XDL_OP_DIR) begin
        if (dir_hit(i_dir_sel, XDL_DIR_CODE[g])) begin
          dir_nxt = acc_r; // [RULE1] [RULE2]
        end
      end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
        dir_r <= XDL_DIR_RST;
      end else begin
        dir_r <= dir_nxt;
      end
    end
  end

  // Write port pulses one cycle; address and data hold until the next write
  always_comb begin
    we_nxt = XDL_PULSE_RST;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    if (op == XDL_OP_FILE && i_dest_sel == XDL_DEST_FILE) begin
      we_nxt = 1'h1; // [RULE4]
      waddr_nxt = i_file_addr; // [RULE4]
      wdata_nxt = file_res; // [RULE4]
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      we_r <= XDL_PULSE_RST;
      waddr_r <= XDL_WADDR_RST;
      wdata_r <= XDL_WDATA_RST;
    end else begin
      we_r <= we_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // Operand outside five to seven changes nothing and is flagged
  always_comb begin
    ill_nxt = XDL_PULSE_RST;
    if (op == XDL_OP_DIR && !dir_legal(i_dir_sel)) begin
      ill_nxt = 1'h1; // [RULE1]
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ill_r <= XDL_PULSE_RST;
    end else begin
      ill_r <= ill_nxt;
    end
  end

  assign o_acc = acc_r;
  assign o_zero = zero_r;
  assign o_port_a_direction_reg = g_dir[0].dir_r;
  assign o_port_b_direction_reg = g_dir[1].dir_r;
  assign o_port_c_direction_reg = g_dir[2].dir_r;
  assign o_file_we = we_r;
  assign o_file_waddr = waddr_r;
  assign o_file_wdata = wdata_r;
  assign o_illegal_operand = ill_r;
endmodule

// ===== verif/xdl_exec_chk.sv
// Purpose: Concurrent checks on the execution block ports
// Assumes: At most one instruction strobe a cycle
// Notes: Bound into every instance of the block below
`timescale 1ns/10ps
module xdl_chk (
  input logic i_sys_clk,
  input logic i_reset,
  input logic i_load_port_direction,
  input logic [2:0] i_dir_sel,
  input logic i_xor_literal_into_acc,
  input logic [7:0] i_literal,
  input logic i_xor_acc_with_file,
  input logic [6:0] i_file_addr,
  input logic i_dest_sel,
  input logic [7:0] i_file_rdata,
  input logic [7:0] o_acc,
  input logic o_zero,
  input logic [7:0] o_port_a_direction_reg,
  input logic [7:0] o_port_b_direction_reg,
  input logic [7:0] o_port_c_direction_reg,
  input logic o_file_we,
  input logic [6:0] o_file_waddr,
  input logic [7:0] o_file_wdata,
  input logic o_illegal_operand
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  sequence s_lit_take;
    !i_load_port_direction && i_xor_literal_into_acc;
  endsequence
  sequence s_file_take;
    !i_load_port_direction && !i_xor_literal_into_acc && i_xor_acc_with_file;
  endsequence
  a_lit_xor: assert property (s_lit_take |=>
    o_acc == ($past(o_acc) ^ $past(i_literal))) else $error("literal xor");
  a_file_xor: assert property (s_file_take ##0 i_dest_sel |=>
    o_file_we && o_file_waddr == $past(i_file_addr)
    && o_file_wdata == ($past(o_acc) ^ $past(i_file_rdata))) else $error("file xor");
  a_file_keep: assert property (s_file_take ##0 i_dest_sel |=>
    $stable(o_acc)) else $error("file xor acc");
  a_file_acc: assert property (s_file_take ##0 !i_dest_sel |=>
    !o_file_we && o_acc == ($past(o_acc) ^ $past(i_file_rdata))) else $error("xor to acc");
  a_zero_set: assert property (s_lit_take |=> o_zero == (o_acc == 8'h00))
    else $error("zero flag");
  a_dir_flag: assert property (i_load_port_direction |=>
    $stable(o_zero) && $stable(o_acc)) else $error("direction flag");
  a_dir_load: assert property (i_load_port_direction && i_dir_sel == 3'h6 |=>
    o_port_b_direction_reg == $past(o_acc)) else $error("direction load");
  a_dir_load_a: assert property (i_load_port_direction && i_dir_sel == 3'h5 |=>
    o_port_a_direction_reg == $past(o_acc)) else $error("direction load a");
  a_dir_load_c: assert property (i_load_port_direction && i_dir_sel == 3'h7 |=>
    o_port_c_direction_reg == $past(o_acc)) else $error("direction load c");
  a_bad_oper: assert property (i_load_port_direction && i_dir_sel < 3'h5 |=>
    o_illegal_operand && $stable(o_port_a_direction_reg)
    && $stable(o_port_b_direction_reg) && $stable(o_port_c_direction_reg))
    else $error("bad operand");
endmodule
bind xdl_exec xdl_chk u_chk (.*);

// ===== verif/tb_top.sv
// Purpose: Bench for the xor and direction-load execution block
// Assumes: 200 MHz clock, one strobe per instruction
// Notes: Table rows first, then hand-written edge cases
`timescale 1ns/10ps
module tb_top;
  logic i_sys_clk = 0, i_reset = 1, i_load_port_direction, i_xor_literal_into_acc;
  logic i_xor_acc_with_file, i_dest_sel, i_zero_in = 0, o_zero, o_file_we, o_illegal_operand;
  logic [2:0] i_dir_sel = 0, st = 0;
  logic [6:0] i_file_addr = 7'h7F, o_file_waddr;
  logic [7:0] i_literal = 0, i_file_rdata, o_acc, o_file_wdata, o_port_a_direction_reg;
  logic [7:0] o_port_b_direction_reg, o_port_c_direction_reg;
  logic [15:0] rows [2] = '{16'h5A5A, 16'h5A00};
  int fail_count = 0, checked = 0;
  assign {i_load_port_direction, i_xor_literal_into_acc, i_xor_acc_with_file} = st;
  assign {i_file_rdata, i_dest_sel} = {i_literal, i_dir_sel[0]};
  xdl_exec dut (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_load_port_direction(i_load_port_direction),
    .i_dir_sel(i_dir_sel),
    .i_xor_literal_into_acc(i_xor_literal_into_acc),
    .i_literal(i_literal),
    .i_xor_acc_with_file(i_xor_acc_with_file),
    .i_file_addr(i_file_addr),
    .i_dest_sel(i_dest_sel),
    .i_file_rdata(i_file_rdata),
    .i_zero_in(i_zero_in),
    .o_acc(o_acc),
    .o_zero(o_zero),
    .o_port_a_direction_reg(o_port_a_direction_reg),
    .o_port_b_direction_reg(o_port_b_direction_reg),
    .o_port_c_direction_reg(o_port_c_direction_reg),
    .o_file_we(o_file_we),
    .o_file_waddr(o_file_waddr),
    .o_file_wdata(o_file_wdata),
    .o_illegal_operand(o_illegal_operand)
  );
  always #2.5 i_sys_clk = ~i_sys_clk;
  task chk(input logic [7:0] g, e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %0t %h %h", $time, g, e);
    end
  endtask
  task op(input logic [2:0] s, input logic [7:0] l, d);
    @(posedge i_sys_clk) #1 st = s;
    {i_literal, i_dir_sel} = {l, d[2:0]};
    @(posedge i_sys_clk) #1 st = 3'h0;
  endtask
  task stop_test;
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #13.5 i_reset = 0;
    foreach (rows[i]) begin
      op(3'h2, rows[i][15:8], 8'h0);
      chk(o_acc, rows[i][7:0]);
    end
    for (int k = 5; k < 8; k++) begin
      op(3'h2, 8'(k), 8'h0);
      op(3'h4, 8'h0, 8'(k));
    end
    chk(o_port_a_direction_reg, 8'h05);
    chk(o_port_b_direction_reg, 8'h03);
    chk(o_port_c_direction_reg, 8'h04);
    op(3'h4, 8'h0, 8'h4);
    chk({7'h00, o_illegal_operand}, 8'h01);
    chk(o_port_a_direction_reg, 8'h05);
    op(3'h1, 8'h04, 8'h1);
    chk({o_zero, o_acc[6:0]}, 8'h84);
    chk({o_file_we, o_file_waddr}, 8'hFF);
    chk(o_file_wdata, 8'h00);
    op(3'h1, 8'h0F, 8'h0);
    chk(o_acc, 8'h0B);
    chk({o_file_we, o_zero, o_file_wdata[5:0]}, 8'h00);
    @(posedge i_sys_clk) #1 i_reset = 1;
    #1 chk(o_acc, 8'h00);
    chk(o_port_c_direction_reg, 8'hFF);
    @(posedge i_sys_clk) #1 i_reset = 0;
    op(3'h2, 8'h3C, 8'h0);
    chk(o_acc, 8'h3C);
    stop_test();
  end
endmodule
